//--- verification/meter_cal_sva.sv
// Checker of the handler's offset and energy ports.
// Assumes a bind from the bench top; sees the top ports only.
`timescale 1ns/1ps
`default_nettype none
module meter_cal_sva #(
   parameter int DC_CHANNEL_CYCLES = 8
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic miso_o,
   input wire logic [2:0] offset_channel_o,
   input wire logic busy_o,
   input wire logic energy_clear_o
);
   int hold, next_hold;
   logic [2:0] prev_ch;
   always_comb begin
      next_hold = (busy_o && offset_channel_o == prev_ch) ? hold + 1 : 0;
   end
   always_ff @(posedge mclk_i) begin
      hold <= reset_i ? 0 : next_hold;
      prev_ch <= offset_channel_o;
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   chk_clear_pulse: assert property (energy_clear_o |=> !energy_clear_o)
      else $error("energy clear longer than one cycle");
   chk_reset_quiet: assert property (disable iff (1'b0) reset_i |=>
      !busy_o && !energy_clear_o && offset_channel_o == 3'h0)
      else $error("outputs active after reset");
   chk_reset_miso: assert property (disable iff (1'b0)
      reset_i && $past(reset_i) |-> !miso_o) else $error("reply during reset");
   chk_chan_range: assert property (busy_o |-> offset_channel_o < 3'h6)
      else $error("channel out of range");
   chk_chan_first: assert property ($rose(busy_o) |->
      offset_channel_o == 3'h0)
      else $error("calculation not started at channel zero");
   chk_chan_step: assert property (busy_o && $past(busy_o) &&
      offset_channel_o != $past(offset_channel_o) |->
      offset_channel_o == $past(offset_channel_o) + 3'h1 &&
      hold >= DC_CHANNEL_CYCLES - 2) else $error("channel step wrong");
   chk_busy_last: assert property ($fell(busy_o) |->
      $past(offset_channel_o) == 3'h5) else $error("calculation ended early");
   chk_clear_busy: assert property (busy_o |-> !energy_clear_o)
      else $error("energy clear during calculation");
endmodule
`default_nettype wire

//--- verification/meter_calibration_command_handler_tb_top.sv
// Bench top: host model, handler and checker bind.
// Assumes a short offset count so the calculation finishes quickly.
`timescale 1ns/1ps
`default_nettype none
module meter_calibration_command_handler_tb_top;
   localparam int DC_CHANNEL_CYCLES = 8;
   typedef struct packed {
      logic [7:0] cmd;
      logic [47:0] data;
      logic [7:0] ack;
   } row_t;
   logic mclk_i, reset_i, sclk_i, cs_n_i, mosi_i, miso_o, busy_o;
   logic energy_clear_o, got;
   logic [2:0] offset_channel_o;
   logic [7:0] rx;
   int err_count, num_checks, clr_seen;
   row_t rows[7] = '{{8'h86, 48'h1234_0000_0000, 8'hb6},
      {8'h88, 48'h2345_0000_0000, 8'hb8}, {8'h8a, 48'h3456_0000_0000, 8'hba},
      {8'h82, 48'h7000_7001_7002, 8'hb2}, {8'h95, 48'h2108_2209_230a, 8'hc5},
      {8'h16, 48'h0, 8'h46}, {8'h81, 48'h1111_2222_3333, 8'hb1}};
   spi_host_model i_host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .mosi_o(mosi_i),
                          .miso_i(miso_o));
   meter_calibration_command_handler #(
      .DC_CHANNEL_CYCLES(DC_CHANNEL_CYCLES)
   ) i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .sclk_i(sclk_i),
      .cs_n_i(cs_n_i), .mosi_i(mosi_i), .miso_o(miso_o),
      .offset_measure_i({13'h0a50, offset_channel_o}),
      .offset_channel_o(offset_channel_o), .busy_o(busy_o),
      .energy_clear_o(energy_clear_o));
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) if (energy_clear_o === 1'b1) clr_seen++;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (err_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Ack rides the second filler after the last byte
   task automatic send(input row_t r);
      if (r.cmd < 8'h80) i_host.xfer(r.cmd, rx);
      else i_host.packet(8'hee, r.cmd, {r.data, 8'h00}, 8'h00);
      i_host.xfer(8'h00, rx);
      i_host.xfer(8'h00, rx);
      check(rx, r.ack);
   endtask
   task automatic read_words(input logic [7:0] cmd, input int n,
                             input logic [95:0] exp);
      logic [7:0] hi;
      i_host.xfer(cmd, rx);
      i_host.xfer(8'h00, rx);
      for (int k = 0; k < n; k++) begin
         i_host.xfer(8'h00, hi);
         i_host.xfer(8'h00, rx);
         check({hi, rx}, exp[95-16*k -: 16]);
      end
   endtask
   // A refused packet leaves the reply slot after its last byte empty
   task automatic expect_silence;
      i_host.xfer(8'h00, rx);
      i_host.xfer(8'h00, rx);
      check(rx, 8'h00);
   endtask
   initial begin
      #100us;
      err_count++;
      tally_and_finish();
   end
   initial begin
      reset_i = 1'b1;
      repeat (2) @(posedge mclk_i);
      #1 reset_i = 1'b0;
      repeat (4) @(posedge mclk_i);
      check({miso_o, busy_o, energy_clear_o, offset_channel_o}, 16'h0);
      send({8'h18, 48'h0, 8'h48});
      read_words(8'h01, 3, {48'h709c_709c_709c, 48'h0});
      foreach (rows[i]) send(rows[i]);
      read_words(8'h01, 3, {48'h1111_2222_3333, 48'h0});
      i_host.packet(8'hee, 8'h86, 56'h0, 8'h01);
      expect_silence();
      i_host.packet(8'hed, 8'h86, 56'h0, 8'h00);
      expect_silence();
      i_host.packet(8'hee, 8'h77, 56'h0, 8'h00);
      expect_silence();
      send({8'h77, 48'h0, 8'h00});
      i_host.xfer(8'h0d, rx);
      // Sent while the calculation runs and must be dropped
      i_host.xfer(8'h16, rx);
      got = 1'b0;
      for (int i = 0; i < 30 && !got; i++) begin
         i_host.xfer(8'h00, rx);
         got = (rx === 8'h3d);
      end
      check(got, 1'b1);
      check(clr_seen, 1);
      read_words(8'h0e, 6, 96'h5280_5281_5282_5283_5284_5285);
      // Reset in mid-calculation must drop busy and the channel at once
      i_host.xfer(8'h0d, rx);
      @(posedge mclk_i);
      #1 check(busy_o, 1'b1);
      reset_i = 1'b1;
      repeat (2) @(posedge mclk_i);
      #1 reset_i = 1'b0;
      repeat (4) @(posedge mclk_i);
      check({miso_o, busy_o, energy_clear_o, offset_channel_o}, 16'h0);
      tally_and_finish();
   end
endmodule
bind meter_calibration_command_handler meter_cal_sva #(
   .DC_CHANNEL_CYCLES(DC_CHANNEL_CYCLES)
) i_sva (.mclk_i(mclk_i), .reset_i(reset_i), .miso_o(miso_o),
   .offset_channel_o(offset_channel_o), .busy_o(busy_o),
   .energy_clear_o(energy_clear_o));
`default_nettype wire

//--- verification/spi_host_model.sv
// Host end of the serial link: mode 0, msb first, 12 ns sclk.
// Assumes the caller spaces commands; sclk stands low between bytes.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o,
   input wire logic miso_i
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // Reply bit taken just before the rising edge that shifts it on, so
   // the sample never races the link register update
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      cs_n_o = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         mosi_o = tx[i];
         #6;
         rx[i] = miso_i;
         sclk_o = 1'b1;
         #6 sclk_o = 1'b0;
      end
      cs_n_o = 1'b1;
      mosi_o = ~tx[0];
      // Gap covers the byte spacing and the store write after a packet
      #200;
   endtask
   // The caller reads the ack from a filler afterwards; the task never resends after silence
   task automatic packet(input logic [7:0] mark, input logic [7:0] cmd,
                         input logic [55:0] data, input logic [7:0] skew);
      logic [7:0] sum;
      logic [7:0] rx;
      sum = mark + cmd;
      xfer(mark, rx);
      xfer(cmd, rx);
      for (int i = 6; i >= 0; i--) begin
         sum = sum + data[i*8 +: 8];
         xfer(data[i*8 +: 8], rx);
      end
      xfer(sum + skew, rx);
   endtask
endmodule
`default_nettype wire

//--- verilog/const_store.sv
// Calibration constant store, written and read a word at a time.
// Assumes one clock; read data come from a register one edge later.
`timescale 1ns/1ps
`default_nettype none

module const_store #(
   parameter int DEPTH = 16
) (
   input wire logic mclk_i,
   store_if.store port
);
   logic [meter_cal_pkg::WORD_W-1:0] words [DEPTH];
   logic [meter_cal_pkg::WORD_W-1:0] next_rdata;
   logic [meter_cal_pkg::WORD_W-1:0] rdata;

   always_comb begin
      next_rdata = words[port.raddr];
   end

   always_ff @(posedge mclk_i) begin
      if (port.we) begin
         words[port.waddr] <= port.wdata;
      end
      rdata <= next_rdata;
   end

   assign port.rdata = rdata;
endmodule

`default_nettype wire

//--- verilog/meter_cal_if.sv
// Carriers between the command handler and its two helpers.
// Assumes byte_link_if signals all live in the system clock domain.
`timescale 1ns/1ps
`default_nettype none

interface byte_link_if;
   logic [7:0] rx_byte;
   logic rx_valid;
   logic [7:0] tx_byte;
   logic tx_load;
   modport link (output rx_byte, output rx_valid,
                 input tx_byte, input tx_load);
   modport parser (input rx_byte, input rx_valid,
                   output tx_byte, output tx_load);
endinterface

interface store_if;
   logic we;
   logic [meter_cal_pkg::STORE_AW-1:0] waddr;
   logic [meter_cal_pkg::WORD_W-1:0] wdata;
   logic [meter_cal_pkg::STORE_AW-1:0] raddr;
   logic [meter_cal_pkg::WORD_W-1:0] rdata;
   modport store (input we, input waddr, input wdata, input raddr,
                  output rdata);
   modport user (output we, output waddr, output wdata, output raddr,
                 input rdata);
endinterface

`default_nettype wire

//--- verilog/meter_cal_pkg.sv
// Constants of the calibration command handler: packet layout,
// command codes, store map, default constants and timing.
// Assumes a 100 MHz system clock.
package meter_cal_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int DC_CHANNEL_TIME_US = 100;
   localparam int DC_CHANNEL_CYCLES =
      (DC_CHANNEL_TIME_US * 1000) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Packet layout
   // ---------------------------------------------------------------
   localparam logic [7:0] PACKET_START_MARKER = 8'hee;
   localparam logic [3:0] PACKET_LAST_INDEX = 4'h9;
   localparam logic [7:0] ACK_OFFSET = 8'h30;
   localparam logic [7:0] IDLE_TX_BYTE = 8'h00;

   // ---------------------------------------------------------------
   // Command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_WRITE_VOLTAGE = 8'h81;
   localparam logic [7:0] CMD_WRITE_LOW_GAIN_CURRENT = 8'h82;
   localparam logic [7:0] CMD_WRITE_PHASE_A_LOW_CURRENT_POWER = 8'h86;
   localparam logic [7:0] CMD_WRITE_PHASE_B_LOW_CURRENT_POWER = 8'h88;
   localparam logic [7:0] CMD_WRITE_PHASE_C_LOW_CURRENT_POWER = 8'h8a;
   localparam logic [7:0] CMD_WRITE_PHASE_COMPENSATION = 8'h95;
   localparam logic [7:0] CMD_DC_OFFSET = 8'h0d;
   localparam logic [7:0] CMD_READ_DC_OFFSET = 8'h0e;
   localparam logic [7:0] CMD_ENERGY_CLEAR = 8'h16;
   localparam logic [7:0] CMD_CAL_RESET = 8'h18;
   localparam logic [7:0] CMD_READ_VOLTAGE = 8'h01;

   // ---------------------------------------------------------------
   // Constant store map, one 16-bit word per entry
   // ---------------------------------------------------------------
   localparam int STORE_AW = 4;
   localparam int WORD_W = 16;
   localparam logic [3:0] ADDR_VOLTAGE_A = 4'h0;
   localparam logic [3:0] ADDR_LOW_POWER_A = 4'h3;
   localparam logic [3:0] ADDR_PHASE_COMP_A = 4'h6;
   localparam logic [3:0] ADDR_DC_OFFSET_0 = 4'h9;
   localparam logic [3:0] STORE_LAST_ADDR = 4'he;
   localparam logic [3:0] PHASE_WORDS = 4'h3;
   localparam logic [3:0] DC_CHANNELS = 4'h6;

   // ---------------------------------------------------------------
   // Defaults restored by a calibration reset
   // ---------------------------------------------------------------
   localparam logic [15:0] DEFAULT_VOLTAGE = 16'h709c;
   localparam logic [15:0] DEFAULT_LOW_POWER = 16'h0aa0;
   localparam logic [7:0] DEFAULT_GUARD = 8'h20;
   localparam logic [7:0] DEFAULT_START = 8'h08;
   localparam logic [15:0] DEFAULT_DC_OFFSET = 16'h0000;

endpackage

//--- verilog/meter_calibration_command_handler.sv
// Command interpreter for calibration packets and special commands
// arriving over the serial link.
// Assumes the host leaves at least a few hundred ns between bytes and
// clocks filler bytes to collect acknowledgments and read data.
`timescale 1ns/1ps
`default_nettype none

module meter_calibration_command_handler #(
   parameter int DC_CHANNEL_CYCLES = meter_cal_pkg::DC_CHANNEL_CYCLES
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   input wire logic [15:0] offset_measure_i,
   output logic [2:0] offset_channel_o,
   output logic busy_o,
   output logic energy_clear_o
);
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_COLLECT = 6'b000010,
      ST_STORE = 6'b000100,
      ST_DEFAULTS = 6'b001000,
      ST_DC_CALC = 6'b010000,
      ST_READ = 6'b100000
   } state_t;

   localparam logic [31:0] DC_RELOAD = 32'(DC_CHANNEL_CYCLES - 1);

   byte_link_if link ();
   store_if store ();

   spi_byte_link u_link (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .sclk_i(sclk_i),
      .cs_n_i(cs_n_i),
      .mosi_i(mosi_i),
      .miso_o(miso_o),
      .sys(link.link)
   );

   const_store #(.DEPTH(16)) u_store (
      .mclk_i(mclk_i),
      .port(store.store)
   );

   // ---------------------------------------------------------------
   // Defaults per store address
   // ---------------------------------------------------------------
   function automatic logic [15:0] default_word(input logic [3:0] a);
      logic [15:0] w;
      if (a < meter_cal_pkg::ADDR_LOW_POWER_A) begin
         w = meter_cal_pkg::DEFAULT_VOLTAGE;
      end else if (a < meter_cal_pkg::ADDR_PHASE_COMP_A) begin
         w = meter_cal_pkg::DEFAULT_LOW_POWER;
      end else if (a < meter_cal_pkg::ADDR_DC_OFFSET_0) begin
         w = {meter_cal_pkg::DEFAULT_GUARD, meter_cal_pkg::DEFAULT_START};
      end else begin
         w = meter_cal_pkg::DEFAULT_DC_OFFSET;
      end
      return w;
   endfunction

   // ---------------------------------------------------------------
   // Interpreter state
   // ---------------------------------------------------------------
   state_t state, next_state;
   logic [8:1][7:0] pkt, next_pkt;
   logic [7:0] sum, next_sum;
   logic [3:0] idx, next_idx;
   logic [3:0] wr_base, next_wr_base;
   logic [3:0] wr_last, next_wr_last;
   logic [31:0] cnt, next_cnt;
   logic [3:0] rd_addr, next_rd_addr;
   logic [3:0] rd_left, next_rd_left;
   logic [1:0] rd_step, next_rd_step;
   logic [7:0] tx_byte, next_tx_byte;
   logic tx_load, next_tx_load;
   logic mem_we, next_mem_we;
   logic [3:0] mem_waddr, next_mem_waddr;
   logic [15:0] mem_wdata, next_mem_wdata;
   logic [2:0] next_offset_channel;
   logic next_busy, next_energy_clear;
   logic [7:0] cmd;
   logic [3:0] lo_sel;

   always_comb begin
      next_state = state;
      next_pkt = pkt;
      next_sum = sum;
      next_idx = idx;
      next_wr_base = wr_base;
      next_wr_last = wr_last;
      next_cnt = cnt;
      next_rd_addr = rd_addr;
      next_rd_left = rd_left;
      next_rd_step = rd_step;
      next_tx_byte = tx_byte;
      next_tx_load = 1'b0;
      next_mem_we = 1'b0;
      next_mem_waddr = mem_waddr;
      next_mem_wdata = mem_wdata;
      next_offset_channel = offset_channel_o;
      next_busy = busy_o;
      next_energy_clear = 1'b0;
      cmd = pkt[1];
      lo_sel = 4'({idx[2:0], 1'b0} + 4'h2);
      case (state)
         ST_IDLE: begin
            if (link.rx_valid) begin
               next_idx = 4'h0;
               next_tx_byte = link.rx_byte + meter_cal_pkg::ACK_OFFSET;
               next_rd_step = 2'h0;
               case (link.rx_byte)
                  meter_cal_pkg::PACKET_START_MARKER: begin
                     next_sum = link.rx_byte;
                     next_idx = 4'h1;
                     next_state = ST_COLLECT;
                  end
                  meter_cal_pkg::CMD_DC_OFFSET: begin
                     next_cnt = DC_RELOAD;
                     next_offset_channel = 3'h0;
                     next_busy = 1'b1;
                     next_state = ST_DC_CALC;
                  end
                  meter_cal_pkg::CMD_ENERGY_CLEAR: begin
                     next_energy_clear = 1'b1;
                     next_tx_load = 1'b1;
                  end
                  meter_cal_pkg::CMD_CAL_RESET: begin
                     next_tx_load = 1'b1;
                     next_state = ST_DEFAULTS;
                  end
                  meter_cal_pkg::CMD_READ_VOLTAGE: begin
                     next_rd_addr = meter_cal_pkg::ADDR_VOLTAGE_A;
                     next_rd_left = meter_cal_pkg::PHASE_WORDS;
                     next_state = ST_READ;
                  end
                  meter_cal_pkg::CMD_READ_DC_OFFSET: begin
                     next_rd_addr = meter_cal_pkg::ADDR_DC_OFFSET_0;
                     next_rd_left = meter_cal_pkg::DC_CHANNELS;
                     next_state = ST_READ;
                  end
                  default: begin
                     next_state = ST_IDLE;
                  end
               endcase
            end
         end
         ST_COLLECT: begin
            if (link.rx_valid) begin
               if (idx == meter_cal_pkg::PACKET_LAST_INDEX) begin
                  next_state = ST_IDLE;
                  next_idx = 4'h0;
                  next_tx_byte = cmd + meter_cal_pkg::ACK_OFFSET;
                  next_wr_last = meter_cal_pkg::PHASE_WORDS - 4'h1;
                  // Padding bytes are summed but never inspected
                  if (link.rx_byte == sum) begin
                     next_tx_load = 1'b1;
                     next_state = ST_STORE;
                     case (cmd)
                        meter_cal_pkg::CMD_WRITE_VOLTAGE: begin
                           next_wr_base = meter_cal_pkg::ADDR_VOLTAGE_A;
                        end
                        meter_cal_pkg::CMD_WRITE_LOW_GAIN_CURRENT: begin
                           next_state = ST_IDLE;
                        end
                        meter_cal_pkg::CMD_WRITE_PHASE_A_LOW_CURRENT_POWER:
                        begin
                           next_wr_base = meter_cal_pkg::ADDR_LOW_POWER_A;
                           next_wr_last = 4'h0;
                        end
                        meter_cal_pkg::CMD_WRITE_PHASE_B_LOW_CURRENT_POWER:
                        begin
                           next_wr_base = meter_cal_pkg::ADDR_LOW_POWER_A
                              + 4'h1;
                           next_wr_last = 4'h0;
                        end
                        meter_cal_pkg::CMD_WRITE_PHASE_C_LOW_CURRENT_POWER:
                        begin
                           next_wr_base = meter_cal_pkg::ADDR_LOW_POWER_A
                              + 4'h2;
                           next_wr_last = 4'h0;
                        end
                        meter_cal_pkg::CMD_WRITE_PHASE_COMPENSATION: begin
                           next_wr_base = meter_cal_pkg::ADDR_PHASE_COMP_A;
                        end
                        default: begin
                           next_tx_load = 1'b0;
                           next_state = ST_IDLE;
                        end
                     endcase
                  end
               end else begin
                  next_pkt[idx] = link.rx_byte;
                  next_sum = sum + link.rx_byte;
                  next_idx = idx + 4'h1;
               end
            end
         end
         ST_STORE: begin
            // Word k pairs its high byte with the byte after it
            next_mem_we = 1'b1;
            next_mem_waddr = wr_base + idx;
            next_mem_wdata = {pkt[lo_sel], pkt[lo_sel + 4'h1]};
            next_idx = idx + 4'h1;
            if (idx == wr_last) begin
               next_state = ST_IDLE;
            end
         end
         ST_DEFAULTS: begin
            next_mem_we = 1'b1;
            next_mem_waddr = idx;
            next_mem_wdata = default_word(idx);
            next_idx = idx + 4'h1;
            if (idx == meter_cal_pkg::STORE_LAST_ADDR) begin
               next_state = ST_IDLE;
            end
         end
         ST_DC_CALC: begin
            // Bytes arriving now are dropped on purpose
            if (cnt == 32'h0) begin
               next_mem_we = 1'b1;
               next_mem_waddr = meter_cal_pkg::ADDR_DC_OFFSET_0 + idx;
               next_mem_wdata = offset_measure_i;
               next_idx = idx + 4'h1;
               next_cnt = DC_RELOAD;
               next_offset_channel = 3'(idx + 4'h1);
               if (idx == meter_cal_pkg::DC_CHANNELS - 4'h1) begin
                  next_tx_load = 1'b1;
                  next_busy = 1'b0;
                  next_offset_channel = 3'h0;
                  next_state = ST_IDLE;
               end
            end else begin
               next_cnt = cnt - 32'h1;
            end
         end
         ST_READ: begin
            case (rd_step)
               2'h0: begin
                  next_rd_step = 2'h1;
               end
               2'h1: begin
                  next_tx_byte = store.rdata[15:8];
                  next_tx_load = 1'b1;
                  next_rd_step = 2'h2;
               end
               2'h2: begin
                  if (link.rx_valid) begin
                     next_tx_byte = store.rdata[7:0];
                     next_tx_load = 1'b1;
                     next_rd_left = rd_left - 4'h1;
                     next_rd_addr = rd_addr + 4'h1;
                     next_rd_step = 2'h3;
                     if (rd_left == 4'h1) begin
                        next_state = ST_IDLE;
                     end
                  end
               end
               default: begin
                  if (link.rx_valid) begin
                     next_rd_step = 2'h0;
                  end
               end
            endcase
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         state <= ST_IDLE;
         pkt <= '0;
         sum <= 8'h00;
         idx <= 4'h0;
         wr_base <= 4'h0;
         wr_last <= 4'h0;
         cnt <= 32'h0;
         rd_addr <= 4'h0;
         rd_left <= 4'h0;
         rd_step <= 2'h0;
         tx_byte <= 8'h00;
         tx_load <= 1'b0;
         mem_we <= 1'b0;
         mem_waddr <= 4'h0;
         mem_wdata <= 16'h0000;
         offset_channel_o <= 3'h0;
         busy_o <= 1'b0;
         energy_clear_o <= 1'b0;
      end else begin
         state <= next_state;
         pkt <= next_pkt;
         sum <= next_sum;
         idx <= next_idx;
         wr_base <= next_wr_base;
         wr_last <= next_wr_last;
         cnt <= next_cnt;
         rd_addr <= next_rd_addr;
         rd_left <= next_rd_left;
         rd_step <= next_rd_step;
         tx_byte <= next_tx_byte;
         tx_load <= next_tx_load;
         mem_we <= next_mem_we;
         mem_waddr <= next_mem_waddr;
         mem_wdata <= next_mem_wdata;
         offset_channel_o <= next_offset_channel;
         busy_o <= next_busy;
         energy_clear_o <= next_energy_clear;
      end
   end

   assign link.tx_byte = tx_byte;
   assign link.tx_load = tx_load;
   assign store.we = mem_we;
   assign store.waddr = mem_waddr;
   assign store.wdata = mem_wdata;
   assign store.raddr = rd_addr;
endmodule

`default_nettype wire

//--- verilog/spi_byte_link.sv
// Serial link end: shifts bytes in and out on the host's clock and
// passes them to the system clock domain by toggle crossings.
// Assumes mode 0 framing: data sampled on rising sclk, msb first,
// chip select low for the whole frame.
`timescale 1ns/1ps
`default_nettype none

module spi_byte_link (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   byte_link_if.link sys
);
   // ---------------------------------------------------------------
   // Link domain
   // ---------------------------------------------------------------
   logic [2:0] bit_cnt;
   logic [7:0] rx_sh, rx_hold, tx_sh;
   logic rx_tog, tx_seen, tx_s1, tx_s2;
   logic [7:0] next_rx_sh, next_rx_hold, next_tx_sh;
   logic next_rx_tog, next_tx_seen;
   logic [7:0] tx_data;
   logic tx_tog;

   always_comb begin
      next_rx_sh = {rx_sh[6:0], mosi_i};
      next_rx_hold = rx_hold;
      next_rx_tog = rx_tog;
      next_tx_seen = tx_seen;
      next_tx_sh = {tx_sh[6:0], 1'b0};
      if (bit_cnt == 3'h7) begin
         next_rx_hold = {rx_sh[6:0], mosi_i};
         next_rx_tog = ~rx_tog;
         // Reply bytes are only taken at a byte boundary
         if (tx_s2 != tx_seen) begin
            next_tx_sh = tx_data;
            next_tx_seen = tx_s2;
         end else begin
            next_tx_sh = meter_cal_pkg::IDLE_TX_BYTE;
         end
      end
   end

   // Reset acts without the link clock, which stands still outside
   // frames
   always_ff @(posedge sclk_i or posedge reset_i) begin
      if (reset_i) begin
         rx_sh <= 8'h00;
         rx_hold <= 8'h00;
         rx_tog <= 1'b0;
         tx_sh <= 8'h00;
         tx_seen <= 1'b0;
         tx_s1 <= 1'b0;
         tx_s2 <= 1'b0;
      end else begin
         rx_sh <= next_rx_sh;
         rx_hold <= next_rx_hold;
         rx_tog <= next_rx_tog;
         tx_sh <= next_tx_sh;
         tx_seen <= next_tx_seen;
         tx_s1 <= tx_tog;
         tx_s2 <= tx_s1;
      end
   end

   // Deselect realigns the byte boundary
   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         bit_cnt <= 3'h0;
      end else begin
         bit_cnt <= bit_cnt + 3'h1;
      end
   end

   assign miso_o = tx_sh[7];

   // ---------------------------------------------------------------
   // System domain
   // ---------------------------------------------------------------
   logic rx_s1, rx_s2, rx_s3;
   logic [7:0] rx_byte, next_rx_byte, next_tx_data;
   logic rx_valid, next_rx_valid, next_tx_tog;

   always_comb begin
      next_rx_valid = rx_s2 ^ rx_s3;
      next_rx_byte = rx_byte;
      if (rx_s2 ^ rx_s3) begin
         next_rx_byte = rx_hold;
      end
      next_tx_data = tx_data;
      next_tx_tog = tx_tog;
      if (sys.tx_load) begin
         next_tx_data = sys.tx_byte;
         next_tx_tog = ~tx_tog;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         rx_s1 <= 1'b0;
         rx_s2 <= 1'b0;
         rx_s3 <= 1'b0;
         rx_byte <= 8'h00;
         rx_valid <= 1'b0;
         tx_data <= 8'h00;
         tx_tog <= 1'b0;
      end else begin
         rx_s1 <= rx_tog;
         rx_s2 <= rx_s1;
         rx_s3 <= rx_s2;
         rx_byte <= next_rx_byte;
         rx_valid <= next_rx_valid;
         tx_data <= next_tx_data;
         tx_tog <= next_tx_tog;
      end
   end

   assign sys.rx_byte = rx_byte;
   assign sys.rx_valid = rx_valid;
endmodule

`default_nettype wire
